// ### design/dfp_pkg.sv
// Purpose: constants for the bridge fault supervisor
// Assumes: 125 MHz clock, AXI4-Lite register access
// Notes: times kept in ns, cycle counts derived here
package dfp_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_SHORT = 5'h04;
   localparam logic [4:0] ADDR_STATUS = 5'h08;
   localparam logic [4:0] ADDR_IRQ_STAT = 5'h0c;
   localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;
   // control word fields
   localparam int CTRL_EN = 0;
   localparam int CTRL_OTSEL = 1;
   localparam int CTRL_LSDIS = 3;
   localparam int CTRL_HSDIS = 4;
   // short detector config fields
   localparam int SC_LS_LVL = 0;
   localparam int SC_HS_LVL = 8;
   localparam int SC_FILT = 16;
   localparam int SC_DLY = 20;
   // level limits, filter code after reset
   localparam logic [3:0] LS_LVL_MIN = 4'h4;
   localparam logic [3:0] HS_LVL_MIN = 4'h2;
   localparam logic [1:0] FILT_RST = 2'h1;
   localparam logic [1:0] RETRIES = 2'h3;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_NS = 8;
   localparam int FILT0_NS = 100;
   localparam int FILT1_NS = 1000;
   localparam int FILT2_NS = 2000;
   localparam int FILT3_NS = 3000;
   localparam int DLY0_NS = 750;
   localparam int DLY1_NS = 1500;
   localparam int RETRY_NS = 1000;
   // least times, rounded up to whole cycles
   localparam int FILT0_CYC = (FILT0_NS + CLK_NS - 1) / CLK_NS;
   localparam int FILT1_CYC = (FILT1_NS + CLK_NS - 1) / CLK_NS;
   localparam int FILT2_CYC = (FILT2_NS + CLK_NS - 1) / CLK_NS;
   localparam int FILT3_CYC = (FILT3_NS + CLK_NS - 1) / CLK_NS;
   localparam int DLY0_CYC = (DLY0_NS + CLK_NS - 1) / CLK_NS;
   localparam int DLY1_CYC = (DLY1_NS + CLK_NS - 1) / CLK_NS;
   localparam int RETRY_CYC = (RETRY_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// ### design/dfp_fault_supervisor.sv
// Purpose: temperature, short and open load supervision of two bridges
// Assumes: detector inputs synchronous to aclk
// Notes: registers over AXI4-Lite, one level interrupt
`timescale 1ns/1ps
// Operation
// - prewarn flag; shutdown at selected threshold
// - shutdown holds until prewarn clears
// - three retries before continuous shutdown
// - switch off only faulty bridge, flag type
// - restart needs driver disable then enable
// - low-side level 4..15, default from OTP
// - high-side level 2..15
// - two-bit filter: 100ns,1us,2us,3us
// - delay select: 750ns or 1500ns
// - low-side disable kills supply short protection
// - high-side disable kills ground short protection
// - open load flag when current unreached
// - no open load evaluation at standstill
// - open load flags never affect bridges
// - level outputs steer low/high side detectors
module dfp_fault_supervisor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic temp_prewarn,
   input wire logic [2:0] temp_over,
   input wire logic [1:0] ls_short,
   input wire logic [1:0] hs_short,
   input wire logic [1:0] bridge_switch,
   input wire logic motor_standstill,
   input wire logic [1:0] coil_eval,
   input wire logic [1:0] coil_reached,
   input wire logic [3:0] otp_lowside_level,
   input wire logic [3:0] otp_highside_level,
   output logic [1:0] bridge_enable,
   output logic [3:0] lowside_short_level,
   output logic [3:0] highside_short_level,
   output logic irq
);
   typedef struct packed {
      logic drv_en;
      logic [1:0] ot_sel;
      logic lowside_short_disable;
      logic highside_short_disable;
      logic [3:0] ls_lvl;
      logic [3:0] hs_lvl;
      logic [1:0] filt;
      logic dly;
      logic otp_done;
      logic overtemp_shutdown_flag;
      logic prewarn;
      logic [1:0][8:0] since_sw;
      logic [1:0][8:0] filt_cnt;
      logic [1:0][1:0] retry;
      logic [1:0][7:0] pause;
      logic [1:0] shut;
      logic [1:0] gnd_flag;
      logic [1:0] sup_flag;
      logic [1:0] ol;
      logic [1:0] br_en;
      logic [5:0] irq_stat;
      logic [5:0] irq_mask;
      logic aw_hold;
      logic [4:0] aw_addr;
      logic w_hold;
      logic [31:0] w_data;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } dfp_state_type;

   dfp_state_type s;
   dfp_state_type next_s;
   logic [1:0] conf;
   logic ot_trip;

   // level clamp: below the legal floor reads as the floor
   function automatic logic [3:0] dfp_clamp(input logic [3:0] v,
                                            input logic [3:0] lo);
      dfp_clamp = (v < lo) ? lo : v;
   endfunction

   // filter code to cycles
   function automatic logic [8:0] dfp_filt_cyc(input logic [1:0] c);
      unique case (c)
         2'h0: dfp_filt_cyc = 9'(dfp_pkg::FILT0_CYC);
         2'h1: dfp_filt_cyc = 9'(dfp_pkg::FILT1_CYC);
         2'h2: dfp_filt_cyc = 9'(dfp_pkg::FILT2_CYC);
         2'h3: dfp_filt_cyc = 9'(dfp_pkg::FILT3_CYC);
      endcase
   endfunction

   // status word, shared by read mux
   function automatic logic [31:0] dfp_status(input dfp_state_type q);
      dfp_status = {20'h00000, q.br_en, q.shut, q.ol, q.sup_flag,
                    q.gnd_flag, q.overtemp_shutdown_flag, q.prewarn};
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic det;
      logic hs_hit;
      logic [8:0] dneed;
      logic [5:0] ev;
      logic wr;
      logic rd_irq;
      det = 1'b0;
      hs_hit = 1'b0;
      dneed = s.dly ? 9'(dfp_pkg::DLY1_CYC) : 9'(dfp_pkg::DLY0_CYC);
      ev = 6'h00;
      rd_irq = 1'b0;
      wr = 1'b0;
      next_s = s;
      conf = 2'h0;
      // strap capture one cycle after reset release
      if (!s.otp_done) begin
         next_s.otp_done = 1'b1;
         next_s.ls_lvl = dfp_clamp(otp_lowside_level,
                                   dfp_pkg::LS_LVL_MIN);
         next_s.hs_lvl = dfp_clamp(otp_highside_level,
                                   dfp_pkg::HS_LVL_MIN);
         next_s.filt = dfp_pkg::FILT_RST;
      end
      // thermal: select one of three thresholds, code 3 = highest
      ot_trip = (s.ot_sel == 2'h3) ? temp_over[2] : temp_over[s.ot_sel];
      next_s.prewarn = temp_prewarn;
      // latch holds while prewarn is still up, avoids heat cycling
      next_s.overtemp_shutdown_flag = ot_trip
         | (s.overtemp_shutdown_flag & temp_prewarn);
      ev[0] = next_s.overtemp_shutdown_flag & ~s.overtemp_shutdown_flag;
      ev[1] = temp_prewarn & ~s.prewarn;
      // per bridge short handling
      for (int i = 0; i < 2; i++) begin
         det = (ls_short[i] & ~s.lowside_short_disable)
             | (hs_short[i] & ~s.highside_short_disable);
         hs_hit = hs_short[i] & ~s.highside_short_disable;
         next_s.since_sw[i] = bridge_switch[i] ? 9'h000
            : (s.since_sw[i] == 9'h1ff ? s.since_sw[i]
               : s.since_sw[i] + 9'h001);
         next_s.filt_cnt[i] = !det ? 9'h000
            : (s.filt_cnt[i] == 9'h1ff ? s.filt_cnt[i]
               : s.filt_cnt[i] + 9'h001);
         // spike filter plus blanking after a switch edge
         conf[i] = det && s.br_en[i]
            && (s.filt_cnt[i] + 9'h001 >= dfp_filt_cyc(s.filt))
            && (s.since_sw[i] >= dneed);
         if (s.pause[i] != 8'h00) begin
            next_s.pause[i] = s.pause[i] - 8'h01;
         end
         if (conf[i]) begin
            next_s.filt_cnt[i] = 9'h000;
            if (s.retry[i] == dfp_pkg::RETRIES) begin
               next_s.shut[i] = 1'b1;
               next_s.gnd_flag[i] = hs_hit;
               next_s.sup_flag[i] = ~hs_hit;
               ev[2 + i] = 1'b1;
            end else begin
               // transient: brief off time, then try again
               next_s.retry[i] = s.retry[i] + 2'h1;
               next_s.pause[i] = 8'(dfp_pkg::RETRY_CYC);
            end
         end
         // disabling the driver arms a fresh start
         if (!s.drv_en) begin
            next_s.shut[i] = 1'b0;
            next_s.retry[i] = 2'h0;
            next_s.pause[i] = 8'h00;
         end
         // open load: only judged while moving, never acts
         if (coil_eval[i] && !motor_standstill) begin
            next_s.ol[i] = ~coil_reached[i];
            ev[4 + i] = ~coil_reached[i] & ~s.ol[i];
         end
         next_s.br_en[i] = next_s.drv_en & ~next_s.shut[i]
            & ~next_s.overtemp_shutdown_flag
            & (next_s.pause[i] == 8'h00);
      end
      // ------------------------------------------------------------
      // axi write path: address and data in either order
      // ------------------------------------------------------------
      if (s_axi_awvalid && s_axi_awready) begin
         next_s.aw_hold = 1'b1;
         next_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_s.w_hold = 1'b1;
         next_s.w_data = s_axi_wdata;
         for (int b = 0; b < 4; b++) begin
            if (!s_axi_wstrb[b]) begin
               next_s.w_data[8*b +: 8] = 8'h00;
            end
         end
      end
      wr = s.aw_hold && s.w_hold && !s.bvalid;
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (wr) begin
         next_s.aw_hold = 1'b0;
         next_s.w_hold = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = dfp_pkg::RESP_OK;
         unique case (s.aw_addr)
            dfp_pkg::ADDR_CTRL: begin
               next_s.drv_en = s.w_data[dfp_pkg::CTRL_EN];
               next_s.ot_sel = s.w_data[dfp_pkg::CTRL_OTSEL +: 2];
               next_s.lowside_short_disable =
                  s.w_data[dfp_pkg::CTRL_LSDIS];
               next_s.highside_short_disable =
                  s.w_data[dfp_pkg::CTRL_HSDIS];
            end
            dfp_pkg::ADDR_SHORT: begin
               next_s.ls_lvl = dfp_clamp(
                  s.w_data[dfp_pkg::SC_LS_LVL +: 4],
                  dfp_pkg::LS_LVL_MIN);
               next_s.hs_lvl = dfp_clamp(
                  s.w_data[dfp_pkg::SC_HS_LVL +: 4],
                  dfp_pkg::HS_LVL_MIN);
               next_s.filt = s.w_data[dfp_pkg::SC_FILT +: 2];
               next_s.dly = s.w_data[dfp_pkg::SC_DLY];
            end
            dfp_pkg::ADDR_STATUS, dfp_pkg::ADDR_IRQ_STAT: begin
            end
            dfp_pkg::ADDR_IRQ_MASK: begin
               next_s.irq_mask = s.w_data[5:0];
            end
            default: begin
               next_s.bresp = dfp_pkg::RESP_ERR;
            end
         endcase
      end
      // ------------------------------------------------------------
      // axi read path, one cycle answer
      // ------------------------------------------------------------
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = dfp_pkg::RESP_OK;
         next_s.rdata = 32'h00000000;
         unique case (s_axi_araddr)
            dfp_pkg::ADDR_CTRL: next_s.rdata[4:0] =
               {s.highside_short_disable, s.lowside_short_disable,
                s.ot_sel, s.drv_en};
            dfp_pkg::ADDR_SHORT: next_s.rdata[20:0] =
               {s.dly, 2'h0, s.filt, 4'h0, s.hs_lvl, 4'h0, s.ls_lvl};
            dfp_pkg::ADDR_STATUS: next_s.rdata = dfp_status(s);
            dfp_pkg::ADDR_IRQ_STAT: begin
               next_s.rdata[5:0] = s.irq_stat;
               rd_irq = 1'b1;
            end
            dfp_pkg::ADDR_IRQ_MASK: next_s.rdata[5:0] = s.irq_mask;
            default: next_s.rresp = dfp_pkg::RESP_ERR;
         endcase
      end
      // read clears, but an event in the same cycle survives
      next_s.irq_stat = (rd_irq ? 6'h00 : s.irq_stat) | ev;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = !s.aw_hold && !s.bvalid;
   assign s_axi_wready = !s.w_hold && !s.bvalid;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = !s.rvalid;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign bridge_enable = s.br_en;
   assign lowside_short_level = s.ls_lvl;
   assign highside_short_level = s.hs_lvl;
   assign irq = |(s.irq_stat & s.irq_mask);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_last_retry;
      s.retry[0] == 2'h3 && conf[0] && s.drv_en;
   endsequence
   sequence s_off_next;
      ##1 s.shut[0] && !bridge_enable[0];
   endsequence

   a_ot_forces_off: assert property (
      s.overtemp_shutdown_flag |-> bridge_enable == 2'h0)
      else $error("bridges on during overtemp");
   a_ot_release: assert property (
      s.overtemp_shutdown_flag && !temp_prewarn && !ot_trip
      |=> !s.overtemp_shutdown_flag)
      else $error("overtemp not released");
   a_ot_threshold: assert property (
      s.ot_sel == 2'h1 && temp_over[1] |=> s.overtemp_shutdown_flag)
      else $error("selected threshold ignored");
   a_short_latch: assert property (
      s_last_retry |-> s_off_next)
      else $error("short not latched");
   a_restart_seq: assert property (
      s.shut[0] && !s.drv_en |=> !s.shut[0])
      else $error("disable did not clear shutdown");
   a_switch_blank: assert property (
      bridge_switch[0] |=> !conf[0] [*8])
      else $error("short confirmed inside blanking");
   a_both_disabled: assert property (
      s.lowside_short_disable && s.highside_short_disable
      |-> conf == 2'h0)
      else $error("short confirmed while disabled");
   a_ol_standstill: assert property (
      motor_standstill && s.otp_done |=> $stable(s.ol))
      else $error("open load judged at standstill");
   a_ls_level_floor: assert property (
      s.otp_done |-> lowside_short_level >= dfp_pkg::LS_LVL_MIN)
      else $error("low-side level below floor");
   // a latch needs the last of the retries used up
   a_retry_count: assert property (
      $rose(s.shut[0]) |-> s.retry[0] == dfp_pkg::RETRIES)
      else $error("shutdown latched before retries spent");
   // only a driver disable may lift a short shutdown
   a_shut_holds: assert property (
      s.shut[0] && s.drv_en |=> s.shut[0])
      else $error("short shutdown lifted while enabled");
   // the thermal latch holds while prewarn still stands
   a_ot_hold: assert property (
      s.overtemp_shutdown_flag && temp_prewarn
      |=> s.overtemp_shutdown_flag)
      else $error("overtemp released during prewarn");
   // no confirm before the shortest filter time
   a_filter_floor: assert property (
      conf[0] |-> s.filt_cnt[0] >= 9'(dfp_pkg::FILT0_CYC - 1))
      else $error("short confirmed inside filter time");
   // no confirm before the shorter detection delay
   a_delay_floor: assert property (
      conf[1] |-> s.since_sw[1] >= 9'(dfp_pkg::DLY0_CYC))
      else $error("short confirmed inside detection delay");
   // a status bit survives until a read can clear it
   a_irq_sticky: assert property (
      s.irq_stat[2] && !(s_axi_arvalid && s_axi_arready)
      |=> s.irq_stat[2])
      else $error("status bit lost without a read");
endmodule

// ### verif/dfp_partner.sv
// Purpose: stand-in for the two power bridges, coils and detectors
// Assumes: shorts and open coils are commanded by the bench
// Notes: a detector only sees a drop while its bridge drives
`timescale 1ns/1ps
module dfp_partner (
   input wire logic aclk,
   input wire logic [1:0] bridge_enable,
   input wire logic [1:0] gnd_cmd,
   input wire logic [1:0] sup_cmd,
   input wire logic [1:0] open_cmd,
   output logic [1:0] hs_short,
   output logic [1:0] ls_short,
   output logic [1:0] bridge_switch,
   output logic [1:0] coil_eval,
   output logic [1:0] coil_reached
);
   // ---------------------------------------------------------------
   // chopper timing
   // ---------------------------------------------------------------
   logic [8:0] cnt = 9'h000;

   // free running chopper period counter
   always_ff @(posedge aclk) begin
      cnt <= cnt + 9'h001;
   end

   // a bridge that is off does not switch
   assign bridge_switch = {2{cnt == 9'h000}} & bridge_enable;
   // regulation cycle ends; an open coil never reaches its current
   assign coil_eval = {2{cnt[5:0] == 6'h20}};
   assign coil_reached = ~open_cmd;
   // ---------------------------------------------------------------
   // detectors
   // ---------------------------------------------------------------
   // high side sees the switch drop, low side switch plus sense resistor
   assign hs_short = gnd_cmd & bridge_enable;
   assign ls_short = sup_cmd & bridge_enable;
endmodule

// ### verif/testbench.sv
// Purpose: self-checking bench for the bridge fault supervisor
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes: expectations follow the register map of the hand-over
`timescale 1ns/1ps
module testbench;
   logic aclk = 1'b0;
   logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, temp_prewarn, motor_standstill, irq;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, otp_lowside_level, otp_highside_level;
   logic [3:0] lowside_short_level, highside_short_level;
   logic [1:0] s_axi_bresp, s_axi_rresp, ls_short, hs_short, bridge_switch;
   logic [1:0] coil_eval, coil_reached, bridge_enable, bep;
   logic [1:0] gnd_cmd, sup_cmd, open_cmd;
   logic [2:0] temp_over;
   int n_mismatch = 0, checks_done = 0, cyc = 0, fa = 0, fb = 0, f0;

   dfp_fault_supervisor i_dfp_fault_supervisor (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .temp_prewarn, .temp_over, .ls_short, .hs_short,
      .bridge_switch, .motor_standstill, .coil_eval, .coil_reached,
      .otp_lowside_level, .otp_highside_level, .bridge_enable,
      .lowside_short_level, .highside_short_level, .irq);
   dfp_partner i_dfp_partner (.aclk, .bridge_enable, .gnd_cmd, .sup_cmd,
      .open_cmd, .hs_short, .ls_short, .bridge_switch, .coil_eval,
      .coil_reached);

   // ---------------------------------------------------------------
   // clock, timeout, bridge monitor
   // ---------------------------------------------------------------
   always #4 aclk = ~aclk;

   // a hang ends the run as a failure
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         end_sim();
      end
   end

   // counts shutdowns of each bridge, retries included
   always @(posedge aclk) begin
      if (bep[0] === 1'b1 && bridge_enable[0] === 1'b0) fa++;
      if (bep[1] === 1'b1 && bridge_enable[1] === 1'b0) fb++;
      bep <= bridge_enable;
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic end_sim();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // address and data offered together, each released once taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) aw = 1'b0;
         if (s_axi_wready === 1'b1) w = 1'b0;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, r);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] e,
                     input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      // raised only now, so back to back reads never drive it twice
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      aresetn <= 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
      {s_axi_arvalid, s_axi_rready, temp_prewarn} <= 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
      s_axi_wstrb <= 4'hf;
      temp_over <= 3'h0;
      {gnd_cmd, sup_cmd, open_cmd} <= 6'h00;
      motor_standstill <= 1'b1;
      otp_lowside_level <= 4'h2;
      otp_highside_level <= 4'h1;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      wt(3);
      // reset values, level floors, unmapped and read-only places
      chk(lowside_short_level, 32'h4);
      rd(dfp_pkg::ADDR_CTRL, 32'h0, dfp_pkg::RESP_OK);
      rd(dfp_pkg::ADDR_SHORT, 32'h0001_0204, dfp_pkg::RESP_OK);
      wr(dfp_pkg::ADDR_SHORT, 32'h0010_0f03, dfp_pkg::RESP_OK);
      rd(dfp_pkg::ADDR_SHORT, 32'h0010_0f04, dfp_pkg::RESP_OK);
      chk(highside_short_level, 32'hf);
      wr(5'h14, 32'h0, dfp_pkg::RESP_ERR);
      rd(5'h14, 32'h0, dfp_pkg::RESP_ERR);
      wr(dfp_pkg::ADDR_STATUS, 32'hffff, dfp_pkg::RESP_OK);
      // shutdown at the selected threshold, held until prewarn clears
      wr(dfp_pkg::ADDR_CTRL, 32'h5, dfp_pkg::RESP_OK);
      wt(5);
      chk(bridge_enable, 32'h3);
      temp_prewarn <= 1'b1;
      temp_over <= 3'h3;
      wt(10);
      chk(bridge_enable, 32'h3);
      temp_over <= 3'h7;
      wt(4);
      chk(bridge_enable, 32'h0);
      rd(dfp_pkg::ADDR_STATUS, 32'h3, dfp_pkg::RESP_OK);
      temp_over <= 3'h0;
      wt(20);
      chk(bridge_enable, 32'h0);
      chk(irq, 32'h0);
      temp_prewarn <= 1'b0;
      wt(5);
      chk(bridge_enable, 32'h3);
      rd(dfp_pkg::ADDR_IRQ_STAT, 32'h3, dfp_pkg::RESP_OK);
      rd(dfp_pkg::ADDR_IRQ_STAT, 32'h0, dfp_pkg::RESP_OK);
      // a ground short shorter than the 3 us filter is ignored
      wr(dfp_pkg::ADDR_SHORT, 32'h0003_0806, dfp_pkg::RESP_OK);
      wr(dfp_pkg::ADDR_IRQ_MASK, 32'h4, dfp_pkg::RESP_OK);
      f0 = fa;
      gnd_cmd <= 2'h1;
      wt(200);
      gnd_cmd <= 2'h0;
      wt(20);
      chk(fa - f0, 32'h0);
      // held short: three retries, then only bridge A latched off
      wr(dfp_pkg::ADDR_SHORT, 32'h0001_0806, dfp_pkg::RESP_OK);
      gnd_cmd <= 2'h1;
      wt(2500);
      chk(fa - f0, 32'h4);
      chk(bridge_enable, 32'h2);
      chk(irq, 32'h1);
      rd(dfp_pkg::ADDR_STATUS, 32'h904, dfp_pkg::RESP_OK);
      rd(dfp_pkg::ADDR_IRQ_STAT, 32'h4, dfp_pkg::RESP_OK);
      chk(irq, 32'h0);
      gnd_cmd <= 2'h0;
      wt(20);
      chk(bridge_enable, 32'h2);
      wr(dfp_pkg::ADDR_CTRL, 32'h0, dfp_pkg::RESP_OK);
      wr(dfp_pkg::ADDR_CTRL, 32'h1, dfp_pkg::RESP_OK);
      wt(5);
      chk(bridge_enable, 32'h3);
      // supply short on B: ignored while disabled, latched otherwise
      f0 = fb;
      wr(dfp_pkg::ADDR_CTRL, 32'h9, dfp_pkg::RESP_OK);
      sup_cmd <= 2'h2;
      wt(1500);
      chk(bridge_enable, 32'h3);
      wr(dfp_pkg::ADDR_CTRL, 32'h1, dfp_pkg::RESP_OK);
      wt(2500);
      chk(fb - f0, 32'h4);
      // fault flags stand across a restart, so ground A stays set
      rd(dfp_pkg::ADDR_STATUS, 32'h624, dfp_pkg::RESP_OK);
      sup_cmd <= 2'h0;
      wr(dfp_pkg::ADDR_CTRL, 32'h0, dfp_pkg::RESP_OK);
      wr(dfp_pkg::ADDR_CTRL, 32'h11, dfp_pkg::RESP_OK);
      gnd_cmd <= 2'h2;
      wt(1500);
      chk(bridge_enable, 32'h3);
      gnd_cmd <= 2'h0;
      // open coil A: silent at standstill, flagged in motion only
      open_cmd <= 2'h1;
      wt(300);
      rd(dfp_pkg::ADDR_STATUS, 32'hc24, dfp_pkg::RESP_OK);
      motor_standstill <= 1'b0;
      wt(300);
      rd(dfp_pkg::ADDR_STATUS, 32'hc64, dfp_pkg::RESP_OK);
      chk(bridge_enable, 32'h3);
      // middle and top codes of the shutdown select
      wr(dfp_pkg::ADDR_CTRL, 32'h3, dfp_pkg::RESP_OK);
      temp_prewarn <= 1'b1;
      temp_over <= 3'h1;
      wt(5);
      chk(bridge_enable, 32'h3);
      temp_over <= 3'h3;
      wt(4);
      chk(bridge_enable, 32'h0);
      wr(dfp_pkg::ADDR_CTRL, 32'h7, dfp_pkg::RESP_OK);
      temp_prewarn <= 1'b0;
      wt(5);
      chk(bridge_enable, 32'h3);
      temp_over <= 3'h7;
      wt(4);
      chk(bridge_enable, 32'h0);
      end_sim();
   end
endmodule
